// *** dsr_pkg.sv ***
/*
 * Package for the loop status readout: register offsets, field positions,
 * reset values, state codes and the carrier structs shared by the block.
 * Assumes a single 40 MHz clock domain and a byte-wide register port.
 */
package dsr_pkg;

    localparam int unsigned DSR_ADDR_W = 7;
    localparam int unsigned DSR_REF_W = 4;
    localparam int unsigned DSR_NUM_REFS = 14;
    localparam int unsigned DSR_FREQ_W = 19;

    // register offsets
    localparam logic [6:0] DSR_ADDR_FREQ_HIGH = 7'h07;
    localparam logic [6:0] DSR_ADDR_LOOP_OPERATING_STATE = 7'h09;
    localparam logic [6:0] DSR_ADDR_PRIO_A = 7'h0A;
    localparam logic [6:0] DSR_ADDR_PRIO_B = 7'h0B;
    localparam logic [6:0] DSR_ADDR_FREQ_LOW = 7'h0C;
    localparam logic [6:0] DSR_ADDR_FREQ_MID = 7'h0D;
    localparam logic [6:0] DSR_ADDR_VALID_LOW = 7'h0E;
    localparam logic [6:0] DSR_ADDR_VALID_HIGH = 7'h0F;

    // field positions
    localparam int unsigned DSR_POS_AUX_SOFT = 4;
    localparam int unsigned DSR_POS_HI_NIB = 4;
    localparam int unsigned DSR_POS_LO_NIB = 0;

    // reset values, reference codes and frequency limits
    localparam logic [7:0] DSR_RST_BYTE = 8'h00;
    localparam logic [3:0] DSR_REF_NONE = 4'h0;
    localparam logic [3:0] DSR_REF_UNUSED = 4'hF;
    localparam logic [3:0] DSR_REF_MAX = 4'hE;
    localparam logic [18:0] DSR_FREQ_MAX = 19'h3FFFF;
    localparam logic [18:0] DSR_FREQ_MIN = 19'h40000;

    // lsb weight of the frequency report, in ppm
    localparam real DSR_PPM_PER_LSB = 0.0003068;

    typedef enum logic [2:0] {
        DSR_ST_UNUSED = 3'b000,
        DSR_ST_FREE_RUN = 3'b001,
        DSR_ST_HOLDOVER = 3'b010,
        DSR_ST_LOCKED = 3'b100,
        DSR_ST_PRELOCK2 = 3'b101,
        DSR_ST_PRELOCK = 3'b110,
        DSR_ST_LOSS_LOCK = 3'b111
    } dsr_state_t;

    localparam dsr_state_t DSR_ST_RESET = DSR_ST_FREE_RUN;

    // per-loop view from the selection core
    typedef struct packed {
        logic [13:0] cand;
        logic [3:0] selected_ref;
        logic [18:0] integ_freq;
    } dsr_loop_in_t;

    // host port strobes
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
    } dsr_host_req_t;

    typedef struct packed {
        logic [3:0] best_ref;
        logic [3:0] second_ref;
        logic [3:0] third_ref;
        logic [3:0] selected_ref;
    } dsr_rank_t;

    typedef struct packed {
        dsr_state_t main_loop_state;
        logic aux_loop_soft_alarm;
        dsr_rank_t rank;
        logic [18:0] loop_freq_offset;
        logic [2:0] freq_hi_snap;
        logic [7:0] freq_mid_snap;
        logic [13:0] valid_status;
        logic [7:0] rdata;
    } dsr_state_reg_t;

endpackage

// *** dsr_status_readout.sv ***
/*
 * Status readout for the main and auxiliary loops: ranked references,
 * selected reference, operating state, soft alarm and frequency offset.
 * Assumes loop inputs come from logic on clk; the host read strobe and
 * address are synchronous to clk, one cycle per read.
 */
`timescale 1ns/1ps

// Operation
// - aux soft alarm bit is 1 while aux frequency exceeds soft limits
// - main state field codes free-run 001, holdover 010, locked 100
// - prelocked2 101, prelocked 110, loss-of-lock 111; other codes never shown
// - upper nibble of priority A shows best valid ref, 0000 if none
// - view select 0 shows main loop fields, 1 shows aux loop
// - software-invalidated inputs never appear in ranked or selected fields
// - selected ref is not forced to equal best ref
// - input n coded as n, 1..14; code 1111 never reported
// - lower nibble of priority A shows selected ref, 0000 if none
// - upper nibble of priority B shows third ref, 0000 if fewer
// - lower nibble of priority B shows second ref, 0000 if fewer
// - frequency report is 19-bit signed offset of viewed loop
// - bits 7:0 in low frequency byte, 15:8 in mid byte
// - with freeze-at-limit set, report stops at min or max frequency
// - each lsb is a fixed ppm step of 0.0003068
// - frequency taken from loop integral path, an averaged value
// - bits 18:16 in high byte bits 2:0, upper bits zero
module dsr_status_readout
    import dsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire dsr_host_req_t host_req,
    input wire logic loop_view_select,
    input wire logic freeze_at_limit,
    input wire logic revertive_enable,
    input wire logic [13:0] ref_valid_ctrl,
    input wire logic [13:0] input_valid,
    input wire logic [2:0] main_state_raw,
    input wire logic aux_freq_outside_soft,
    input wire dsr_loop_in_t main_loop,
    input wire dsr_loop_in_t aux_loop,
    output logic [7:0] host_rdata,
    output logic [2:0] main_loop_state,
    output logic aux_loop_soft_alarm,
    output dsr_rank_t rank_view,
    output logic [18:0] loop_freq_offset
);

    dsr_state_reg_t s_q;
    dsr_state_reg_t s_d;

    // pick the lowest-numbered set bit; returns code n or 0
    function automatic logic [3:0] first_ref(input logic [13:0] c);
        logic [3:0] r;
        r = DSR_REF_NONE;
        for (int i = DSR_NUM_REFS - 1; i >= 0; i--) begin
            if (c[i]) begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    // clear the bit that a code names, so the next rank can be found
    function automatic logic [13:0] drop_ref(input logic [13:0] c,
                                             input logic [3:0] code);
        logic [13:0] r;
        r = c;
        if (code != DSR_REF_NONE && code <= DSR_REF_MAX) begin
            r[code - 4'h1] = 1'b0;
        end
        return r;
    endfunction

    // only codes 1..14 naming a usable input pass; others read as none
    function automatic logic [3:0] clean_ref(input logic [3:0] code,
                                             input logic [13:0] ok);
        logic [3:0] r;
        r = DSR_REF_NONE;
        if (code != DSR_REF_NONE && code <= DSR_REF_MAX) begin
            if (ok[code - 4'h1]) begin
                r = code;
            end
        end
        return r;
    endfunction

    dsr_loop_in_t view;
    logic [13:0] usable;
    logic [13:0] left1;
    logic [13:0] left2;
    logic [3:0] r1;
    logic [3:0] r2;
    logic [3:0] r3;
    logic at_limit;
    logic freq_rd;

    always_comb begin
        s_d = s_q;
        view = loop_view_select ? aux_loop : main_loop;
        usable = view.cand & input_valid & ref_valid_ctrl;
        r1 = first_ref(usable);
        left1 = drop_ref(usable, r1);
        r2 = first_ref(left1);
        left2 = drop_ref(left1, r2);
        r3 = first_ref(left2);
        s_d.rank.best_ref = r1;
        s_d.rank.second_ref = r2;
        s_d.rank.third_ref = r3;
        // selection passed if usable, else none; not tied to best
        s_d.rank.selected_ref = clean_ref(view.selected_ref, usable);

        // invalid codes keep the last legal state
        case (main_state_raw)
            3'b001: s_d.main_loop_state = DSR_ST_FREE_RUN;
            3'b010: s_d.main_loop_state = DSR_ST_HOLDOVER;
            3'b100: s_d.main_loop_state = DSR_ST_LOCKED;
            3'b101: s_d.main_loop_state = DSR_ST_PRELOCK2;
            3'b110: s_d.main_loop_state = DSR_ST_PRELOCK;
            3'b111: s_d.main_loop_state = DSR_ST_LOSS_LOCK;
            default: s_d.main_loop_state = s_q.main_loop_state;
        endcase

        s_d.aux_loop_soft_alarm = aux_freq_outside_soft;
        s_d.valid_status = input_valid & ref_valid_ctrl;

        // hold once pinned at an end of range
        at_limit = (s_q.loop_freq_offset == DSR_FREQ_MAX) ||
                   (s_q.loop_freq_offset == DSR_FREQ_MIN);
        if (!(freeze_at_limit && at_limit)) begin
            s_d.loop_freq_offset = view.integ_freq;
        end

        freq_rd = host_req.rd && host_req.addr == DSR_ADDR_FREQ_LOW;
        // low byte read freezes upper bytes
        if (freq_rd) begin
            s_d.freq_mid_snap = s_q.loop_freq_offset[15:8];
            s_d.freq_hi_snap = s_q.loop_freq_offset[18:16];
        end

        s_d.rdata = DSR_RST_BYTE;
        if (host_req.rd) begin
            case (host_req.addr)
                DSR_ADDR_LOOP_OPERATING_STATE: begin
                    s_d.rdata[DSR_POS_AUX_SOFT] = s_q.aux_loop_soft_alarm;
                    s_d.rdata[2:0] = s_q.main_loop_state;
                end
                DSR_ADDR_PRIO_A: begin
                    s_d.rdata = {s_q.rank.best_ref, s_q.rank.selected_ref};
                end
                DSR_ADDR_PRIO_B: begin
                    s_d.rdata = {s_q.rank.third_ref, s_q.rank.second_ref};
                end
                DSR_ADDR_FREQ_LOW: begin
                    s_d.rdata = s_q.loop_freq_offset[7:0];
                end
                DSR_ADDR_FREQ_MID: begin
                    s_d.rdata = s_q.freq_mid_snap;
                end
                DSR_ADDR_FREQ_HIGH: begin
                    s_d.rdata = {5'h00, s_q.freq_hi_snap};
                end
                DSR_ADDR_VALID_LOW: begin
                    s_d.rdata = s_q.valid_status[7:0];
                end
                DSR_ADDR_VALID_HIGH: begin
                    s_d.rdata = {2'h0, s_q.valid_status[13:8]};
                end
                default: s_d.rdata = DSR_RST_BYTE;
            endcase
        end
    end

    // revertive mode only matters to the selector; kept for visibility
    logic revertive_enable_unused;
    assign revertive_enable_unused = revertive_enable;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.main_loop_state <= DSR_ST_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign host_rdata = s_q.rdata;
    assign main_loop_state = s_q.main_loop_state;
    assign aux_loop_soft_alarm = s_q.aux_loop_soft_alarm;
    assign rank_view = s_q.rank;
    assign loop_freq_offset = s_q.loop_freq_offset;

endmodule

// *** dsr_status_readout_bench.sv ***
/* bench for the loop status readout: reset, then ranking table,
   state, frequency snapshot, freeze and unmapped read tests.
   assumes the checker file is compiled before it. */
`timescale 1ns/1ps
module dsr_status_readout_bench
    import dsr_pkg::*;
();
    typedef struct packed {
        logic v;
        logic [13:0] vc;
        logic [13:0] cand;
        logic [3:0] sel;
        logic [15:0] e;
    } dsr_row_t;
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, loop_view_select = 1'b0;
    logic freeze_at_limit = 1'b0, revertive_enable = 1'b0;
    logic aux_freq_outside_soft = 1'b0;
    logic [13:0] ref_valid_ctrl = 14'h3FFF, input_valid = 14'h3FFF;
    logic [2:0] main_state_raw = 3'h1;
    dsr_host_req_t host_req = '0;
    dsr_loop_in_t main_loop = '0;
    dsr_loop_in_t aux_loop = {14'h0030, 4'h6, 19'h0ABCD};
    logic [7:0] host_rdata;
    logic [2:0] main_loop_state;
    logic aux_loop_soft_alarm;
    dsr_rank_t rank_view;
    logic [18:0] loop_freq_offset;
    int n_fail = 0, total_checks = 0;
    dsr_row_t rows [6] = '{'{1'b0, 14'h3FFF, 14'h0000, 4'h0, 16'h0000},
        '{1'b0, 14'h3FFF, 14'h0001, 4'h1, 16'h1001},
        '{1'b0, 14'h3FFF, 14'h0003, 4'h2, 16'h1202},
        '{1'b0, 14'h3FFF, 14'h3800, 4'hE, 16'hCDEE},
        '{1'b0, 14'h3FFE, 14'h3FFF, 4'h1, 16'h2340},
        '{1'b1, 14'h3FFF, 14'h0000, 4'h0, 16'h5606}};
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [18:0] lims [2] = '{DSR_FREQ_MAX, DSR_FREQ_MIN};
    always #12.5 clk = ~clk;
    dsr_status_readout dut (.clk, .rst, .clk_en, .host_req, .loop_view_select,
        .freeze_at_limit, .revertive_enable, .ref_valid_ctrl, .input_valid,
        .main_state_raw, .aux_freq_outside_soft, .main_loop, .aux_loop,
        .host_rdata, .main_loop_state, .aux_loop_soft_alarm, .rank_view,
        .loop_freq_offset);
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // status lags one cycle, read data two
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk) host_req <= {1'b1, a};
        @(posedge clk) host_req.rd <= 1'b0;
        #1 chk(host_rdata, e);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1 chk(main_loop_state, 3'h1);
        rd(DSR_ADDR_PRIO_A, 8'h00);
        rd(DSR_ADDR_FREQ_LOW, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge clk) loop_view_select <= rows[i].v;
            ref_valid_ctrl <= rows[i].vc;
            main_loop.cand <= rows[i].cand;
            main_loop.selected_ref <= rows[i].sel;
            settle();
            chk(rank_view, rows[i].e);
            rd(DSR_ADDR_PRIO_A, {rows[i].e[15:12], rows[i].e[3:0]});
            rd(DSR_ADDR_PRIO_B, {rows[i].e[7:4], rows[i].e[11:8]});
        end
        $display("ranking table done");
        foreach (codes[i]) begin
            @(posedge clk) main_state_raw <= codes[i];
            settle();
            chk(main_loop_state, codes[i]);
        end
        @(posedge clk) main_state_raw <= 3'h0;
        aux_freq_outside_soft <= 1'b1;
        settle();
        rd(DSR_ADDR_LOOP_OPERATING_STATE, 8'h17);
        chk(aux_loop_soft_alarm, 1'b1);
        // clock enable low must hold the soft alarm bit
        @(posedge clk) clk_en <= 1'b0;
        aux_freq_outside_soft <= 1'b0;
        settle();
        chk(aux_loop_soft_alarm, 1'b1);
        @(posedge clk) clk_en <= 1'b1;
        settle();
        chk(aux_loop_soft_alarm, 1'b0);
        rd(DSR_ADDR_VALID_LOW, 8'hFF);
        rd(DSR_ADDR_VALID_HIGH, 8'h3F);
        $display("state test done");
        // change the source under the read to expose a torn sample
        @(posedge clk) loop_view_select <= 1'b0;
        main_loop.integ_freq <= 19'h2B3C5;
        settle();
        @(posedge clk) host_req <= {1'b1, DSR_ADDR_FREQ_LOW};
        main_loop.integ_freq <= 19'h11111;
        @(posedge clk) host_req <= {1'b1, DSR_ADDR_FREQ_MID};
        #1 chk(host_rdata, 8'hC5);
        @(posedge clk) host_req <= {1'b1, DSR_ADDR_FREQ_HIGH};
        #1 chk(host_rdata, 8'hB3);
        @(posedge clk) host_req.rd <= 1'b0;
        #1 chk(host_rdata, 8'h02);
        @(posedge clk) loop_view_select <= 1'b1;
        settle();
        chk(loop_freq_offset, 19'h0ABCD);
        @(posedge clk) loop_view_select <= 1'b0;
        foreach (lims[i]) begin
            @(posedge clk) freeze_at_limit <= 1'b1;
            main_loop.integ_freq <= lims[i];
            settle();
            @(posedge clk) main_loop.integ_freq <= 19'h00010;
            settle();
            chk(loop_freq_offset, lims[i]);
            @(posedge clk) freeze_at_limit <= 1'b0;
            settle();
            chk(loop_freq_offset, 19'h00010);
        end
        rd(7'h7F, 8'h00);
        $display("frequency test done");
        complete_run();
    end
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
endmodule
bind dsr_status_readout dsr_status_readout_sva u_sva (.clk, .rst, .clk_en,
    .host_req, .loop_view_select, .freeze_at_limit, .ref_valid_ctrl,
    .input_valid, .main_state_raw, .aux_freq_outside_soft, .main_loop,
    .host_rdata, .main_loop_state, .aux_loop_soft_alarm, .rank_view,
    .loop_freq_offset);

// *** dsr_status_readout_sva.sv ***
/* port checker for the loop status readout.
   assumes it is bound onto dsr_status_readout, one clock domain. */
`timescale 1ns/1ps
module dsr_status_readout_sva
    import dsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire dsr_host_req_t host_req,
    input wire logic loop_view_select,
    input wire logic freeze_at_limit,
    input wire logic [13:0] ref_valid_ctrl,
    input wire logic [13:0] input_valid,
    input wire logic [2:0] main_state_raw,
    input wire logic aux_freq_outside_soft,
    input wire dsr_loop_in_t main_loop,
    input wire logic [7:0] host_rdata,
    input wire logic [2:0] main_loop_state,
    input wire logic aux_loop_soft_alarm,
    input wire dsr_rank_t rank_view,
    input wire logic [18:0] loop_freq_offset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // validity as the ranking saw it, same stage as rank_view
    logic [13:0] ok_q;
    always_ff @(posedge clk) if (clk_en) ok_q <= ref_valid_ctrl & input_valid;
    property p_soft; clk_en |=> aux_loop_soft_alarm == $past(aux_freq_outside_soft); endproperty
    a_soft: assert property (p_soft) else $error("soft alarm wrong");
    property p_st; clk_en && main_state_raw != 3'h0 && main_state_raw != 3'h3
        |=> main_loop_state == $past(main_state_raw); endproperty
    a_st: assert property (p_st) else $error("state not followed");
    property p_legal; !(main_loop_state inside {3'h0, 3'h3}); endproperty
    a_legal: assert property (p_legal) else $error("unused state code");
    property p_inv; rank_view.best_ref != 4'h0
        |-> ok_q[rank_view.best_ref - 4'h1]; endproperty
    a_inv: assert property (p_inv) else $error("invalid ref ranked");
    property p_ord2; rank_view.second_ref != 4'h0
        |-> rank_view.best_ref != 4'h0 && rank_view.best_ref < rank_view.second_ref; endproperty
    a_ord2: assert property (p_ord2) else $error("second ref order");
    property p_ord3; rank_view.third_ref != 4'h0
        |-> rank_view.second_ref != 4'h0 && rank_view.second_ref < rank_view.third_ref; endproperty
    a_ord3: assert property (p_ord3) else $error("third ref order");
    property p_idle; clk_en && !host_req.rd |=> host_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_low; clk_en && host_req.rd && host_req.addr == DSR_ADDR_FREQ_LOW
        |=> host_rdata == $past(loop_freq_offset[7:0]); endproperty
    a_low: assert property (p_low) else $error("low freq byte wrong");
    property p_hi; clk_en && host_req.rd && host_req.addr == DSR_ADDR_FREQ_HIGH
        |=> host_rdata[7:3] == 5'h00; endproperty
    a_hi: assert property (p_hi) else $error("high freq pad bits");
    property p_view; clk_en && !loop_view_select && !freeze_at_limit
        |=> loop_freq_offset == $past(main_loop.integ_freq); endproperty
    a_view: assert property (p_view) else $error("main freq not shown");
endmodule
